//--- core/rffl_pkg.sv
// constants and types for the rf fraction and fastlock configuration block
`default_nettype none
package rffl_pkg;
	localparam int WORD_W = 24;
	localparam int FRAC_W = 22;
	localparam int LO_W = 12;
	localparam int HI_W = 10;
	localparam int TOC_W = 14;
	localparam int CPF_W = 4;
	localparam int CSR_W = 2;
	localparam int CNT_W = 15;
	localparam int MULT_W = 5;
	// address code in the low nibble of each serial word
	localparam logic [3:0] CODE_UPPER = 4'hb;
	localparam logic [3:0] CODE_CTRL = 4'hd;
	localparam int CODE_LSB = 0;
	localparam int CODE_W = 4;
	// upper fraction word layout
	localparam int FD_HI_LSB = 14;
	localparam int FN_HI_LSB = 4;
	// control word layout
	localparam int CSR_LSB = 22;
	localparam int CPF_LSB = 18;
	localparam int TOC_LSB = 4;
	// reset values
	localparam logic [TOC_W-1:0] TOC_RESET = 14'h0000;
	localparam logic [CPF_W-1:0] CPF_RESET = 4'h0;
	localparam logic [CSR_W-1:0] CSR_RESET = 2'h0;
	localparam logic [HI_W-1:0] HI_RESET = 10'h000;
	// timeout codes
	localparam logic [TOC_W-1:0] TOC_HIZ = 14'h0000;
	localparam logic [TOC_W-1:0] TOC_MANUAL = 14'h0001;
	localparam logic [TOC_W-1:0] TOC_LOW = 14'h0002;
	localparam logic [TOC_W-1:0] TOC_HIGH = 14'h0003;
	// slip reduction divisors for codes 0..3
	localparam logic [MULT_W-1:0] SLIP_DIV0 = 5'h01;
	localparam logic [MULT_W-1:0] SLIP_DIV1 = 5'h02;
	localparam logic [MULT_W-1:0] SLIP_DIV2 = 5'h04;
	localparam logic [MULT_W-1:0] SLIP_DIV3 = 5'h10;
	localparam logic [MULT_W-1:0] GAIN_OFF = 5'h00;
	typedef enum logic [2:0] {
		MODE_HIZ = 3'h0,
		MODE_MANUAL = 3'h1,
		MODE_LOW = 3'h2,
		MODE_HIGH = 3'h3,
		MODE_TIMED = 3'h4
	} rffl_mode_t;
	typedef enum logic [1:0] {
		TM_IDLE = 2'h0,
		TM_RUN = 2'h1,
		TM_DONE = 2'h3
	} rffl_tm_state_t;
endpackage : rffl_pkg
`default_nettype wire

//--- core/rffl_timeout.sv
// fastlock timeout counter stepping on comparison cycles
`default_nettype none
module rffl_timeout (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic abort,
	input wire logic [rffl_pkg::CNT_W-1:0] load_val,
	input wire logic pd_tick,
	output logic busy,
	output logic done
);
	typedef struct packed {
		rffl_pkg::rffl_tm_state_t st;
		logic [rffl_pkg::CNT_W-1:0] cnt;
	} rffl_tm_t;

	rffl_tm_t s;
	rffl_tm_t next_s;

	always_comb begin
		next_s = s;
		case (s.st)
			rffl_pkg::TM_IDLE: begin
				if (start && !abort) begin
					next_s.st = rffl_pkg::TM_RUN;
					next_s.cnt = load_val;
				end
			end
			rffl_pkg::TM_RUN: begin
				if (abort) begin
					next_s.st = rffl_pkg::TM_IDLE;
					next_s.cnt = '0;
				end else if (start) begin
					next_s.cnt = load_val;
				end else if (pd_tick) begin
					if (s.cnt <= 15'h0001) begin
						next_s.st = rffl_pkg::TM_DONE;
						next_s.cnt = '0;
					end else begin
						next_s.cnt = s.cnt - 15'h0001;
					end
				end
			end
			default: begin
				next_s.st = rffl_pkg::TM_IDLE;
				if (start && !abort) begin
					next_s.st = rffl_pkg::TM_RUN;
					next_s.cnt = load_val;
				end
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '{st: rffl_pkg::TM_IDLE, cnt: '0};
		end else begin
			s <= next_s;
		end
	end

	assign busy = (s.st == rffl_pkg::TM_RUN);
	assign done = (s.st == rffl_pkg::TM_DONE);
endmodule // rffl_timeout
`default_nettype wire

//--- core/rffl_config.sv
// fraction width selection and fastlock control word logic
`default_nettype none
module rffl_config (
	input wire logic clk,
	input wire logic rst,
	input wire logic [rffl_pkg::WORD_W-1:0] reg_word,
	input wire logic reg_wr,
	input wire logic frac_wide_sel,
	input wire logic [rffl_pkg::LO_W-1:0] rf_frac_numerator_lo,
	input wire logic [rffl_pkg::LO_W-1:0] rf_frac_denominator_lo,
	input wire logic freq_word_wr,
	input wire logic pd_tick,
	output logic [rffl_pkg::FRAC_W-1:0] rf_frac_numerator,
	output logic [rffl_pkg::FRAC_W-1:0] rf_frac_denominator,
	output logic fastlock_active,
	output logic [rffl_pkg::MULT_W-1:0] rf_fastlock_pump_gain,
	output logic [rffl_pkg::MULT_W-1:0] slip_rate_div,
	output logic [rffl_pkg::TOC_W-1:0] rf_fastlock_timeout,
	output logic rf_fastlock_pin_o,
	output logic rf_fastlock_pin_oe
);
	typedef struct packed {
		logic [rffl_pkg::TOC_W-1:0] toc;
		logic [rffl_pkg::CPF_W-1:0] cpf;
		logic [rffl_pkg::CSR_W-1:0] slip_reduction_sel;
		logic [rffl_pkg::HI_W-1:0] fn_hi;
		logic [rffl_pkg::HI_W-1:0] fd_hi;
		logic [rffl_pkg::FRAC_W-1:0] num;
		logic [rffl_pkg::FRAC_W-1:0] den;
		logic active;
		logic [rffl_pkg::MULT_W-1:0] gain;
		logic [rffl_pkg::MULT_W-1:0] div;
		logic pin_o;
		logic pin_oe;
	} rffl_state_t;

	rffl_state_t s;
	rffl_state_t next_s;
	rffl_pkg::rffl_mode_t mode;
	logic tm_busy;
	logic tm_done;
	logic fl_on;

	function automatic rffl_pkg::rffl_mode_t toc_mode(input logic [rffl_pkg::TOC_W-1:0] t);
		if (t == rffl_pkg::TOC_HIZ) begin
			toc_mode = rffl_pkg::MODE_HIZ;
		end else if (t == rffl_pkg::TOC_MANUAL) begin
			toc_mode = rffl_pkg::MODE_MANUAL;
		end else if (t == rffl_pkg::TOC_LOW) begin
			toc_mode = rffl_pkg::MODE_LOW;
		end else if (t == rffl_pkg::TOC_HIGH) begin
			toc_mode = rffl_pkg::MODE_HIGH;
		end else begin
			toc_mode = rffl_pkg::MODE_TIMED;
		end
	endfunction

	function automatic logic [rffl_pkg::FRAC_W-1:0] frac_join(input logic wide,
			input logic [rffl_pkg::HI_W-1:0] hi, input logic [rffl_pkg::LO_W-1:0] lo);
		frac_join = wide ? {hi, lo} : {rffl_pkg::HI_RESET, lo};
	endfunction

	assign mode = toc_mode(s.toc);

	rffl_timeout u_timeout (
		.clk(clk),
		.rst(rst),
		.start(freq_word_wr && mode == rffl_pkg::MODE_TIMED),
		.abort(mode != rffl_pkg::MODE_TIMED),
		.load_val({s.toc, 1'b0}),
		.pd_tick(pd_tick),
		.busy(tm_busy),
		.done(tm_done)
	);

	// manual forces fastlock, timed holds it while counting
	assign fl_on = (mode == rffl_pkg::MODE_MANUAL) || (mode == rffl_pkg::MODE_TIMED && tm_busy);

	always_comb begin
		next_s = s;
		if (reg_wr && reg_word[rffl_pkg::CODE_LSB +: rffl_pkg::CODE_W] == rffl_pkg::CODE_CTRL) begin
			next_s.toc = reg_word[rffl_pkg::TOC_LSB +: rffl_pkg::TOC_W];
			next_s.cpf = reg_word[rffl_pkg::CPF_LSB +: rffl_pkg::CPF_W];
			next_s.slip_reduction_sel = reg_word[rffl_pkg::CSR_LSB +: rffl_pkg::CSR_W];
		end else if (reg_wr && reg_word[rffl_pkg::CODE_LSB +: rffl_pkg::CODE_W] == rffl_pkg::CODE_UPPER) begin
			next_s.fd_hi = reg_word[rffl_pkg::FD_HI_LSB +: rffl_pkg::HI_W];
			next_s.fn_hi = reg_word[rffl_pkg::FN_HI_LSB +: rffl_pkg::HI_W];
		end
		next_s.num = frac_join(frac_wide_sel, s.fn_hi, rf_frac_numerator_lo);
		next_s.den = frac_join(frac_wide_sel, s.fd_hi, rf_frac_denominator_lo);
		next_s.active = fl_on;
		next_s.gain = fl_on ? ({1'b0, s.cpf} + 5'h01) : rffl_pkg::GAIN_OFF;
		case (s.slip_reduction_sel)
			2'h0: next_s.div = rffl_pkg::SLIP_DIV0;
			2'h1: next_s.div = rffl_pkg::SLIP_DIV1;
			2'h2: next_s.div = rffl_pkg::SLIP_DIV2;
			default: next_s.div = rffl_pkg::SLIP_DIV3;
		endcase
		case (mode)
			rffl_pkg::MODE_HIZ: begin
				next_s.pin_oe = 1'b0;
				next_s.pin_o = 1'b0;
			end
			rffl_pkg::MODE_HIGH: begin
				next_s.pin_oe = 1'b1;
				next_s.pin_o = 1'b1;
			end
			rffl_pkg::MODE_TIMED: begin
				next_s.pin_oe = 1'b1;
				next_s.pin_o = tm_busy;
			end
			default: begin
				next_s.pin_oe = 1'b1;
				next_s.pin_o = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '{toc: rffl_pkg::TOC_RESET, cpf: rffl_pkg::CPF_RESET, slip_reduction_sel: rffl_pkg::CSR_RESET,
				fn_hi: rffl_pkg::HI_RESET, fd_hi: rffl_pkg::HI_RESET, num: '0, den: '0,
				active: 1'b0, gain: rffl_pkg::GAIN_OFF, div: rffl_pkg::SLIP_DIV0,
				pin_o: 1'b0, pin_oe: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	assign rf_frac_numerator = s.num;
	assign rf_frac_denominator = s.den;
	assign fastlock_active = s.active;
	assign rf_fastlock_pump_gain = s.gain;
	assign slip_rate_div = s.div;
	assign rf_fastlock_timeout = s.toc;
	assign rf_fastlock_pin_o = s.pin_o;
	assign rf_fastlock_pin_oe = s.pin_oe;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// tick counter for the fastlock period check
	logic [15:0] a_ticks;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			a_ticks <= '0;
		end else if (freq_word_wr) begin
			a_ticks <= '0;
		end else if (tm_busy && pd_tick) begin
			a_ticks <= a_ticks + 16'h0001;
		end
	end

	a_narrow_num: assert property (!frac_wide_sel |=> rf_frac_numerator[21:12] == 10'h000)
		else $error("narrow numerator upper bits not zero");
	a_wide_num: assert property (frac_wide_sel && $stable(s.fn_hi)
		|=> rf_frac_numerator == {$past(s.fn_hi), $past(rf_frac_numerator_lo)})
		else $error("wide numerator not joined");
	a_wide_den: assert property (frac_wide_sel
		|=> rf_frac_denominator == {$past(s.fd_hi), $past(rf_frac_denominator_lo)})
		else $error("wide denominator not joined");
	a_pin_hiz: assert property (s.toc == 14'h0000 |=> !rf_fastlock_pin_oe && !fastlock_active)
		else $error("pin not released in code 0");
	a_pin_levels: assert property ((s.toc == 14'h0002 || s.toc == 14'h0003)
		|=> rf_fastlock_pin_oe && rf_fastlock_pin_o == $past(s.toc[0]) && !fastlock_active)
		else $error("general purpose pin level wrong");
	a_manual_mode: assert property (s.toc == 14'h0001
		|=> fastlock_active && rf_fastlock_pin_oe && !rf_fastlock_pin_o)
		else $error("manual fastlock not forced");
	a_timed_start: assert property (freq_word_wr && s.toc >= 14'h0004 && $stable(s.toc) && !reg_wr
		|=> ##1 fastlock_active && rf_fastlock_pin_o)
		else $error("timed fastlock did not start");
	a_period_len: assert property (tm_done |-> a_ticks == {1'b0, s.toc, 1'b0})
		else $error("fastlock period not twice timeout");
	a_release: assert property (tm_done && s.toc >= 14'h0004 |=> !fastlock_active)
		else $error("fastlock not released at terminal count");
	a_gain_code: assert property (fastlock_active |-> rf_fastlock_pump_gain == $past(s.cpf) + 5'h01)
		else $error("fastlock pump gain wrong");
	a_slip_div: assert property ($stable(s.slip_reduction_sel) |=> slip_rate_div == (5'h01 << (($past(s.slip_reduction_sel) == 2'h3) ? 4 : $past(s.slip_reduction_sel))))
		else $error("slip divisor wrong");

	c_timed_run: cover property (freq_word_wr ##[1:40] tm_done);
	c_manual: cover property (s.toc == 14'h0001 ##1 fastlock_active);
	c_wide: cover property (frac_wide_sel && s.fn_hi != 10'h000);
	c_hiz: cover property (s.toc == 14'h0000 ##1 !rf_fastlock_pin_oe);
endmodule // rffl_config
`default_nettype wire

//--- tb/rffl_host_model.sv
// host controller model writing serial configuration words
`default_nettype none
module rffl_host_model (
	input wire logic clk,
	output logic [rffl_pkg::WORD_W-1:0] reg_word,
	output logic reg_wr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		reg_word = 24'h000000;
		reg_wr = 1'b0;
	end
	// strobe held across one rising edge
	task automatic send(input logic [rffl_pkg::WORD_W-1:0] w);
		@(negedge clk);
		reg_word <= w;
		reg_wr <= 1'b1;
		@(negedge clk);
		reg_wr <= 1'b0;
		// released word must not keep its last value
		reg_word <= ~w;
	endtask
	// upper ten bits come out zero for any value below 4096
	task automatic send_upper(input logic [21:0] num, input logic [21:0] den);
		send({den[21:12], num[21:12], rffl_pkg::CODE_UPPER});
	endtask
endmodule // rffl_host_model
`default_nettype wire

//--- tb/rf_fraction_fastlock_config_tb_top.sv
// self-checking bench for the fraction and fastlock configuration logic
`default_nettype none
module rf_fraction_fastlock_config_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, wide, fw_wr, tick, reg_wr, pin_o, pin_oe, active;
	logic [23:0] reg_word;
	logic [11:0] num_lo, den_lo;
	logic [21:0] num, den;
	logic [4:0] gain, div;
	logic [13:0] toc;
	int error_cnt = 0;
	int n_compared = 0;
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	rffl_host_model host (.clk(clk), .reg_word(reg_word), .reg_wr(reg_wr));
	rffl_config DUT (.clk(clk), .rst(rst), .reg_word(reg_word), .reg_wr(reg_wr),
		.frac_wide_sel(wide), .rf_frac_numerator_lo(num_lo),
		.rf_frac_denominator_lo(den_lo), .freq_word_wr(fw_wr), .pd_tick(tick),
		.rf_frac_numerator(num), .rf_frac_denominator(den), .fastlock_active(active),
		.rf_fastlock_pump_gain(gain), .slip_rate_div(div), .rf_fastlock_timeout(toc),
		.rf_fastlock_pin_o(pin_o), .rf_fastlock_pin_oe(pin_oe));
	task automatic final_report;
		if (error_cnt == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_compared++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle pulse on the tick or the frequency strobe
	task automatic pulse(input bit is_tick);
		@(negedge clk);
		tick = is_tick;
		fw_wr = !is_tick;
		@(negedge clk);
		tick = 1'b0;
		fw_wr = 1'b0;
	endtask
	task automatic t_reset;
		chk({pin_oe, pin_o, active, gain, toc}, 24'h000000);
		chk(div, 24'h000001);
	endtask
	task automatic t_modes;
		logic [4:0] divs [4] = '{5'h01, 5'h02, 5'h04, 5'h10};
		for (int c = 0; c < 4; c++) begin
			host.send({c[1:0], 4'(c + 5), 14'(c), rffl_pkg::CODE_CTRL});
			repeat (2) @(negedge clk);
			chk(toc, 24'(c));
			chk(div, divs[c]);
			chk({pin_oe, pin_o, active}, (c == 0) ? 3'b000 : (c == 3) ? 3'b110 :
				{2'b10, c == 1});
			chk(gain, (c == 1) ? 24'h000007 : 24'h000000);
			pulse(0);
			repeat (2) @(negedge clk);
			chk(active, c == 1);
		end
		host.send({2'h0, 4'h0, 14'h0004, 4'h0});
		repeat (2) @(negedge clk);
		chk({toc, div}, {14'h0003, 5'h10});
	endtask
	task automatic t_frac;
		host.send_upper(22'h2aa5a5, 22'h3fffff);
		num_lo = 12'h5a5;
		den_lo = 12'hfff;
		wide = 1'b0;
		repeat (2) @(negedge clk);
		chk(num, 24'h0005a5);
		chk(den, 24'h000fff);
		wide = 1'b1;
		repeat (2) @(negedge clk);
		chk(num, 24'h2aa5a5);
		chk(den, 24'h3fffff);
		host.send_upper(22'h000abc, 22'h001000);
		num_lo = 12'habc;
		den_lo = 12'h000;
		repeat (2) @(negedge clk);
		chk(num, 24'h000abc);
		chk(den, 24'h001000);
	endtask
	task automatic t_timed;
		host.send({2'h0, 4'hf, 14'h0004, rffl_pkg::CODE_CTRL});
		repeat (2) @(negedge clk);
		chk({pin_oe, pin_o, active}, 3'b100);
		pulse(0);
		repeat (2) @(negedge clk);
		chk({pin_oe, pin_o, active}, 3'b111);
		chk(gain, 24'h000010);
		repeat (5) pulse(1);
		pulse(0);
		for (int i = 1; i <= 8; i++) begin
			pulse(1);
			if (i >= 7) chk(active, 1'b1);
		end
		repeat (2) @(negedge clk);
		chk({pin_oe, pin_o, active, gain}, 8'h80);
	endtask
	initial begin
		rst = 1'b1;
		wide = 1'b0;
		fw_wr = 1'b0;
		tick = 1'b0;
		num_lo = 12'h000;
		den_lo = 12'h000;
		repeat (8) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_reset;
		t_modes;
		t_frac;
		t_timed;
		final_report;
	end
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		final_report;
	end
endmodule // rf_fraction_fastlock_config_tb_top
`default_nettype wire
